// [rtl/rcc_top.v]
// Reset merging and cause recording for the controller core
`include "rcc_defines.vh"
module rcc_top #(
  parameter POWERUP_TIMER_UNIT_CYC = `RCC_CYC_PER_MS,
  parameter BOR_EXT_CYC = `RCC_BOR_EXT_CYC,
  parameter PIN_MIN_CYC = `RCC_PIN_MIN_CYC
) (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_por_event,
  input wire i_brownout_low,
  input wire [2:0] i_powerup_delay_select,
  input wire i_master_clear_pin_n,
  input wire i_soft_reset_exec,
  input wire i_watchdog_expire,
  input wire i_sleep_or_idle,
  input wire i_power_save_exec,
  input wire i_watchdog_clear_exec,
  input wire i_trap_active,
  input wire [3:0] i_trap_level,
  input wire i_trap_req,
  input wire [15:0] i_pinsel_live,
  input wire [15:0] i_pinsel_shadow,
  input wire i_exec_valid,
  input wire [7:0] i_exec_opc_hi,
  input wire i_ptr_use,
  input wire [3:0] i_ptr_idx,
  input wire i_wreg_wr,
  input wire [3:0] i_wreg_wr_idx,
  input wire i_flow_change,
  input wire i_flow_restricted,
  input wire i_clock_ready,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  output reg o_system_reset_line,
  output reg o_cold_reset,
  output reg o_wake,
  output reg o_fetch_start,
  output reg [23:0] o_fetch_addr
);
  // Powerup table in ms, eight settings
  function [7:0] rcc_powerup_timer_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: rcc_powerup_timer_ms = 8'h00;
        3'h1: rcc_powerup_timer_ms = 8'h02;
        3'h2: rcc_powerup_timer_ms = 8'h04;
        3'h3: rcc_powerup_timer_ms = 8'h08;
        3'h4: rcc_powerup_timer_ms = 8'h10;
        3'h5: rcc_powerup_timer_ms = 8'h20;
        3'h6: rcc_powerup_timer_ms = 8'h40;
        default: rcc_powerup_timer_ms = 8'h80;
      endcase
    end
  endfunction

  localparam ST_RUN = 3'h1;
  localparam ST_BOR = 3'h2;
  localparam ST_POWERUP_TIMER = 3'h4;

  reg [2:0] state_q;
  reg [31:0] cnt_q;
  reg [7:0] ms_q;
  reg [31:0] pin_cnt_q;
  reg [2:0] pin_sync_q;
  reg pin_low_q;
  reg pin_rst_q;
  reg por_seen_q;
  reg [15:0] flags_q;
  reg wd_async_q;
  reg pulse_rst_q;
  wire ptr_valid;
  wire [31:0] powerup_timer_target;

  assign powerup_timer_target = POWERUP_TIMER_UNIT_CYC;

  // Power-on seen marker; async reset counts as power-on
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_seen_q <= 1'b1;
    end else if (i_ce) begin
      por_seen_q <= i_por_event;
    end
  end

  // Brown-out extension then power-up timer; restart on every recovery
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_BOR;
      cnt_q <= 32'h0;
      ms_q <= 8'h00;
    end else if (i_ce) begin
      if (i_brownout_low || i_por_event) begin
        state_q <= ST_BOR;
        cnt_q <= 32'h0;
        ms_q <= 8'h00;
      end else begin
        case (state_q)
          ST_BOR: begin
            if (cnt_q >= BOR_EXT_CYC - 1) begin
              state_q <= ST_POWERUP_TIMER;
              cnt_q <= 32'h0;
              ms_q <= 8'h00;
            end else begin
              cnt_q <= cnt_q + 32'h1;
            end
          end
          ST_POWERUP_TIMER: begin
            if (ms_q >= rcc_powerup_timer_ms(i_powerup_delay_select)) begin
              state_q <= ST_RUN;
            end else if (cnt_q >= powerup_timer_target - 1) begin
              cnt_q <= 32'h0;
              ms_q <= ms_q + 8'h01;
            end else begin
              cnt_q <= cnt_q + 32'h1;
            end
          end
          ST_RUN: state_q <= ST_RUN;
          default: state_q <= ST_BOR;
        endcase
      end
    end
  end

  // Pin passes three flops; a change counts when second and third agree
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_sync_q <= 3'h7;
      pin_low_q <= 1'b0;
    end else if (i_ce) begin
      pin_sync_q <= {pin_sync_q[1:0], i_master_clear_pin_n};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_low_q <= ~pin_sync_q[2];
      end
    end
  end

  // Minimum width qualifier rejects glitches shorter than the limit
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_cnt_q <= 32'h0;
      pin_rst_q <= 1'b0;
    end else if (i_ce) begin
      if (!pin_low_q) begin
        pin_cnt_q <= 32'h0;
        pin_rst_q <= 1'b0;
      end else if (pin_cnt_q >= PIN_MIN_CYC - 1) begin
        pin_rst_q <= 1'b1;
      end else begin
        pin_cnt_q <= pin_cnt_q + 32'h1;
      end
    end
  end

  // Event decode for warm sources
  wire run = (state_q == ST_RUN);
  wire ev_soft = run && i_soft_reset_exec;
  wire ev_wd_rst = i_watchdog_expire && !i_sleep_or_idle;
  wire ev_trap = i_trap_active && i_trap_req &&
                 (i_trap_level >= 4'hD) && (i_trap_level <= 4'hF);
  wire ev_mism = (i_pinsel_live != i_pinsel_shadow);
  wire ev_opc = i_exec_valid && (i_exec_opc_hi == `RCC_ILLEGAL_OPC);
  wire ev_uninit = i_ptr_use && !ptr_valid;
  wire ev_sec = i_flow_change && i_flow_restricted;
  wire ev_ill = run && (ev_opc || ev_uninit || ev_sec);
  wire ev_pulse = ev_soft || (run && (ev_trap || ev_mism)) || ev_ill;

  // One-cycle reset pulse for instruction and fault sources
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pulse_rst_q <= 1'b0;
      wd_async_q <= 1'b0;
    end else if (i_ce) begin
      pulse_rst_q <= ev_pulse;
      wd_async_q <= ev_wd_rst && run;
    end
  end

  // Working register valid tracking, cleared by every system reset except the top register
  rcc_wreg_valid #(
    .N(`RCC_NUM_WREG)
  ) u_wreg (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_clear(o_system_reset_line),
    .i_wr_en(i_wreg_wr),
    .i_wr_idx(i_wreg_wr_idx),
    .i_rd_idx(i_ptr_idx),
    .o_valid(ptr_valid)
  );

  // Cause flags; hardware set wins over software write in same cycle
  wire wr_flags = i_wr && (i_addr == `RCC_ADDR_FLAGS);
  reg [15:0] flags_d;
  reg [15:0] set_v;
  always @* begin
    set_v = 16'h0000;
    set_v[`RCC_BIT_BROWNOUT] = i_brownout_low;
    set_v[`RCC_BIT_PIN] = pin_rst_q;
    set_v[`RCC_BIT_SOFT] = ev_soft;
    set_v[`RCC_BIT_WDOG] = i_watchdog_expire;
    set_v[`RCC_BIT_TRAP] = ev_trap && run;
    set_v[`RCC_BIT_MISMATCH] = ev_mism && run;
    set_v[`RCC_BIT_ILLEGAL] = ev_ill;
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = i_wdata & `RCC_FLAGS_MASK;
    end
    if (i_power_save_exec || i_watchdog_clear_exec || i_brownout_low) begin
      flags_d[`RCC_BIT_WDOG] = 1'b0;
    end
    if (i_brownout_low) begin
      flags_d = flags_d & ~(16'hC250 | 16'h0010);
    end
    flags_d = flags_d | set_v;
    if (por_seen_q) begin
      flags_d = `RCC_FLAGS_POR | 16'h0002;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= `RCC_FLAGS_POR | 16'h0002;
    end else if (i_ce) begin
      flags_q <= flags_d;
    end
  end

  // System reset merges all sources; watchdog term enters unregistered, line asserts next cycle
  wire rst_any = !run || pin_rst_q || pulse_rst_q || wd_async_q ||
                 (ev_wd_rst && run);
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_system_reset_line <= 1'b1;
      o_cold_reset <= 1'b1;
      o_wake <= 1'b0;
    end else if (i_ce) begin
      o_system_reset_line <= rst_any;
      o_cold_reset <= !run; // Warm sources keep clock source
      o_wake <= i_watchdog_expire && i_sleep_or_idle;
    end
  end

  // Fetch from zero at reset release, only if clock is ready in that cycle
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fetch_start <= 1'b0;
      o_fetch_addr <= `RCC_RESET_VECTOR;
    end else if (i_ce) begin
      o_fetch_start <= o_system_reset_line && !rst_any && i_clock_ready;
      o_fetch_addr <= `RCC_RESET_VECTOR;
    end
  end

  // Read port, data one cycle after strobe, unmapped reads zero
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      if (i_rd) begin
        case (i_addr)
          `RCC_ADDR_FLAGS: o_rdata <= flags_q;
          `RCC_ADDR_STAT: o_rdata <= {11'h000, pin_low_q, o_cold_reset, state_q};
          default: o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end
endmodule

// [pkg/rcc_defines.vh]
// Constants for the reset cause controller
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH
`define RCC_ADDR_FLAGS 4'h0
`define RCC_ADDR_CTRL 4'h1
`define RCC_ADDR_STAT 4'h2
`define RCC_BIT_POWERON 0
`define RCC_BIT_BROWNOUT 1
`define RCC_BIT_WDOG 4
`define RCC_BIT_SOFT 6
`define RCC_BIT_PIN 7
`define RCC_BIT_MISMATCH 9
`define RCC_BIT_ILLEGAL 14
`define RCC_BIT_TRAP 15
`define RCC_FLAGS_MASK 16'hC2D3
`define RCC_FLAGS_POR 16'h0001
`define RCC_CLK_HZ 20000000
`define RCC_BOR_EXT_US 100
`define RCC_BOR_EXT_CYC ((`RCC_BOR_EXT_US * (`RCC_CLK_HZ / 1000000)))
`define RCC_PIN_MIN_NS 2000
`define RCC_PIN_MIN_CYC ((`RCC_PIN_MIN_NS + 49) / 50)
`define RCC_POWERUP_TIMER_MAX_MS 128
`define RCC_CYC_PER_MS (`RCC_CLK_HZ / 1000)
`define RCC_ILLEGAL_OPC 8'h3F
`define RCC_NUM_WREG 16
`define RCC_RESET_VECTOR 24'h000000
`endif

// [rtl/rcc_wreg_valid.v]
// Working register initialised flags
`include "rcc_defines.vh"
module rcc_wreg_valid #(
  parameter N = `RCC_NUM_WREG
) (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_clear,
  input wire i_wr_en,
  input wire [3:0] i_wr_idx,
  input wire [3:0] i_rd_idx,
  output reg o_valid
);
  reg [N-1:0] valid_q;
  genvar g;
  // Each register valid once written; top register always usable
  generate
    for (g = 0; g < N; g = g + 1) begin : g_v
      always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          valid_q[g] <= (g == N - 1) ? 1'b1 : 1'b0;
        end else if (i_ce) begin
          if (i_clear && g != N - 1) begin
            valid_q[g] <= 1'b0;
          end else if (i_wr_en && i_wr_idx == g) begin
            valid_q[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  // Registered read
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_valid <= 1'b0;
    end else if (i_ce) begin
      o_valid <= valid_q[i_rd_idx];
    end
  end
endmodule

// [tb/rcc_supervisor.sv]
// Supervisory circuit model driving the master clear pin
module rcc_supervisor (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_go,
  input wire [7:0] i_len,
  output logic o_master_clear_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  // Low time counter, loaded on request
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 8'h00;
    end else if (i_go) begin
      cnt_q <= i_len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Driven high when idle, the pin has no pull-up
  assign o_master_clear_pin_n = (cnt_q == 8'h00);
endmodule

// [tb/rcc_chk.sv]
// Port-level assertions for the reset cause controller
module rcc_chk (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_brownout_low,
  input wire [2:0] i_powerup_delay_select,
  input wire i_master_clear_pin_n,
  input wire i_soft_reset_exec,
  input wire i_watchdog_expire,
  input wire i_sleep_or_idle,
  input wire i_trap_active,
  input wire [3:0] i_trap_level,
  input wire i_trap_req,
  input wire i_exec_valid,
  input wire [7:0] i_exec_opc_hi,
  input wire o_system_reset_line,
  input wire o_wake,
  input wire [23:0] o_fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Events only count while running, reset swallows them
  wire run = !o_system_reset_line;
  a_bo_hold: assert property (
    i_brownout_low [*3] |-> o_system_reset_line) else $error("reset low in brown-out");
  a_bo_extend: assert property (
    $fell(i_brownout_low) |-> o_system_reset_line [*6]) else $error("extension short");
  a_powerup_timer_release: assert property (
    $fell(i_brownout_low) && i_powerup_delay_select == 3'h1 ##1 !i_brownout_low [*8]
    |-> (!run) [*8] ##1 (!run) [*7] ##[1:9] run) else $error("power-up delay wrong");
  a_wd_run: assert property (
    i_watchdog_expire && !i_sleep_or_idle && run |=> o_system_reset_line)
    else $error("watchdog missed");
  a_wd_sleep: assert property (
    i_watchdog_expire && i_sleep_or_idle && run |=> run ##[0:1] (o_wake && run))
    else $error("sleep watchdog wrong");
  a_soft_pulse: assert property (
    i_soft_reset_exec && run |-> ##2 o_system_reset_line ##1 run) else $error("soft pulse wrong");
  a_trap_conflict: assert property (
    i_trap_req && i_trap_active && i_trap_level >= 4'hD && run |-> ##2 o_system_reset_line)
    else $error("trap conflict missed");
  a_opc_illegal: assert property (
    i_exec_valid && i_exec_opc_hi == 8'h3F && run |-> ##2 o_system_reset_line)
    else $error("illegal opcode missed");
  a_pin_reset: assert property (
    !i_master_clear_pin_n [*8] |=> o_system_reset_line) else $error("pin reset missed");
  a_fetch_zero: assert property (
    $fell(o_system_reset_line) |-> o_fetch_addr == 24'h000000) else $error("fetch not zero");
endmodule
bind rcc_top rcc_chk u_chk (.i_sys_clk, .i_arst_n, .i_brownout_low, .i_powerup_delay_select,
  .i_master_clear_pin_n, .i_soft_reset_exec, .i_watchdog_expire, .i_sleep_or_idle,
  .i_trap_active, .i_trap_level, .i_trap_req, .i_exec_valid, .i_exec_opc_hi,
  .o_system_reset_line, .o_wake, .o_fetch_addr);

// [tb/rcc_top_tb.sv]
// Self-checking bench for the reset cause controller
module rcc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, por = 0, bo = 0, sleep = 0, hot = 1, wr = 0, rd = 0, go = 0;
  logic [3:0] tlev = 4'hD, pidx = 4'h3, addr = 4'h0;
  logic [7:0] opc = 8'h3F, len = 8'h00;
  logic [8:0] pl = 9'h000;
  logic [15:0] shadow = 16'h0000, wdata = 16'h0000, rdv;
  logic [15:0] hit [8] = '{16'h0040, 16'h0010, 16'h0000, 16'h0000,
    16'h8000, 16'h4000, 16'h4000, 16'h4000};
  logic crdy = 1;
  logic [2:0] psel = 3'h1;
  logic [15:0] live = 16'h0000;
  wire pin_n, sys_rst, cold, wake, fst;
  wire [15:0] rdata;
  wire [23:0] faddr;
  int fails = 0, compares = 0, cyc = 0, starts = 0, wakes = 0, n0 = 0;
  // Shortened counts keep the run brief
  rcc_top #(.POWERUP_TIMER_UNIT_CYC(10), .BOR_EXT_CYC(5), .PIN_MIN_CYC(3)) dut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_ce(1'b1), .i_por_event(por), .i_brownout_low(bo),
    .i_powerup_delay_select(psel), .i_master_clear_pin_n(pin_n), .i_soft_reset_exec(pl[0]),
    .i_watchdog_expire(pl[1]), .i_sleep_or_idle(sleep), .i_power_save_exec(pl[2]),
    .i_watchdog_clear_exec(pl[3]), .i_trap_active(hot), .i_trap_level(tlev),
    .i_trap_req(pl[4]), .i_pinsel_live(live), .i_pinsel_shadow(shadow),
    .i_exec_valid(pl[5]), .i_exec_opc_hi(opc), .i_ptr_use(pl[6]), .i_ptr_idx(pidx),
    .i_wreg_wr(pl[8]), .i_wreg_wr_idx(pidx), .i_flow_change(pl[7]), .i_flow_restricted(hot),
    .i_clock_ready(crdy), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_system_reset_line(sys_rst), .o_cold_reset(cold), .o_wake(wake),
    .o_fetch_start(fst), .o_fetch_addr(faddr));
  // Pulse outputs stand one cycle, so count them as they pass
  always @(posedge clk) begin
    starts += fst;
    wakes += wake;
  end
  rcc_supervisor sup (.i_sys_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_len(len),
    .o_master_clear_pin_n(pin_n));
  initial forever #25 clk = ~clk;
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pl <= 9'h001 << b;
    @(posedge clk);
    pl <= 9'h000;
  endtask
  // Let any reset run out, bounded, then read the cause flags
  task automatic flags(input logic [15:0] e);
    int n;
    n = 0;
    repeat (6) @(posedge clk);
    while (sys_rst !== 1'b0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    rdr(4'h0);
    cmp(rdv, e, "flags");
  endtask
  task automatic sv(input logic [7:0] n);
    @(posedge clk);
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    flags(16'h0003);
    cmp({15'h0000, cold}, 16'h0000, "cold after release");
    rdr(4'h7);
    cmp(rdv, 16'h0000, "unmapped");
    wrr(4'h0, 16'hFFFF);
    rdr(4'h0);
    cmp(rdv, 16'hC2D3, "flag write");
    cmp({15'h0000, sys_rst}, 16'h0000, "write reset");
    // Second pass turns every cause benign except the soft reset and the sleep watchdog, which wakes and keeps its flag
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 8; b++) begin
        sleep <= (p == 1 && b == 1);
        wrr(4'h0, (b == 2 || b == 3) ? 16'h0010 : 16'h0000);
        pulse(b);
        flags((p == 1 && b > 1) ? 16'h0000 : hit[b]);
      end
      hot <= 1'b0;
      tlev <= 4'hC;
      opc <= 8'h3E;
      pidx <= 4'hF;
    end
    sleep <= 1'b0;
    hot <= 1'b1;
    pidx <= 4'h3;
    pulse(8);
    pulse(6);
    flags(16'h0000);
    @(posedge clk) shadow <= 16'h0001;
    @(posedge clk) shadow <= 16'h0000;
    flags(16'h0200);
    wrr(4'h0, 16'h80D0);
    bo <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp({15'h0000, cold}, 16'h0001, "cold in brown-out");
    bo <= 1'b0;
    repeat (3) @(posedge clk);
    bo <= 1'b1;
    repeat (4) @(posedge clk);
    bo <= 1'b0;
    flags(16'h0082);
    wrr(4'h0, 16'h0000);
    sv(8'h02);
    flags(16'h0000);
    sv(8'h14);
    flags(16'h0080);
    // Release without a ready clock must not start the fetch
    n0 = starts;
    crdy <= 1'b0;
    pulse(0);
    flags(16'h00C0);
    cmp(16'(starts - n0), 16'h0000, "fetch without clock");
    crdy <= 1'b1;
    pulse(0);
    flags(16'h00C0);
    cmp(16'(starts - n0), 16'h0001, "fetch start");
    cmp(faddr[15:0], 16'h0000, "fetch address");
    cmp(16'(wakes), 16'h0001, "wake count");
    wrr(4'h0, 16'h4000);
    por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    flags(16'h0003);
    end_sim();
  end
endmodule
